// ==== verification/pfl_flag_sva.sv ====
/*
 Assertions on the flag timing and register answers of pfl_flag_logic.
 Bound to every pfl_flag_logic; sees its ports only, one clock domain.
*/
`timescale 1ns/10ps
module pfl_flag_sva
	import pfl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic master_reset_pulse_i,
	input wire logic offset_load_select_i,
	input wire logic default_offset_select_0_i,
	input wire logic default_offset_select_1_i,
	input wire logic flag_timing_select_i,
	input wire logic fall_through_mode_i,
	input wire logic narrow_mode_i,
	input wire logic write_clock_i,
	input wire logic read_clock_i,
	input wire logic offset_readback_i,
	input wire logic almost_full_flag_n_o,
	input wire logic almost_empty_flag_n_o,
	input wire logic input_ready_flag_n_o,
	input wire logic output_ready_flag_n_o,
	input wire logic [PFL_Q_W-1:0] parallel_output_bus_o,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o
);
	localparam logic [11:0] DEF [0:15] = '{12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h01f,
		12'h007, 12'h00f, 12'h003, 12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h3ff, 12'h00f,
		12'h01f, 12'h007};
	logic wd, rd, sync_q, fall_through_mode_q;
	logic [3:0] sel_q;
	wire logic we = write_clock_i & ~wd;
	wire logic re = read_clock_i & ~rd;
	// Straps only count while master reset is high
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			{wd, rd, sync_q, fall_through_mode_q, sel_q} <= '0;
		end else begin
			wd <= write_clock_i;
			rd <= read_clock_i;
			if (master_reset_pulse_i) begin
				sync_q <= flag_timing_select_i;
				fall_through_mode_q <= fall_through_mode_i;
				sel_q <= {narrow_mode_i, offset_load_select_i, default_offset_select_1_i,
					default_offset_select_0_i};
			end
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_mr_end;
		master_reset_pulse_i ##1 !master_reset_pulse_i;
	endsequence
	a_def_readback: assert property (s_mr_end ##0 offset_readback_i
		|=> parallel_output_bus_o == {6'h00, DEF[sel_q]}) else $error("Default offset wrong");
	a_mr_flags: assert property (master_reset_pulse_i
		|=> !almost_empty_flag_n_o && almost_full_flag_n_o) else $error("Reset flags wrong");
	a_paf_sync: assert property (sync_q && !$past(we) && !$past(master_reset_pulse_i)
		|-> $stable(almost_full_flag_n_o)) else $error("Almost-full moved off write edge");
	a_pae_sync: assert property (sync_q && !$past(re) && !$past(master_reset_pulse_i)
		|-> $stable(almost_empty_flag_n_o)) else $error("Almost-empty moved off read edge");
	a_paf_fall: assert property (!sync_q && $fell(almost_full_flag_n_o) |-> $past(we))
		else $error("Almost-full fell off write edge");
	a_paf_rise: assert property (!sync_q && $rose(almost_full_flag_n_o)
		&& !$past(master_reset_pulse_i) |-> $past(re)) else $error("Almost-full rose off read edge");
	a_pae_fall: assert property (!sync_q && $fell(almost_empty_flag_n_o)
		&& !$past(master_reset_pulse_i) |-> $past(re)) else $error("Almost-empty fell off read edge");
	a_pae_rise: assert property (!sync_q && $rose(almost_empty_flag_n_o) |-> $past(we))
		else $error("Almost-empty rose off write edge");
	a_or_moves: assert property (fall_through_mode_q && !$past(re) && !$past(re, 2)
		&& !$past(master_reset_pulse_i) && !$past(master_reset_pulse_i, 2)
		|-> $stable(output_ready_flag_n_o)) else $error("Output ready moved off read edge");
	a_ir_moves: assert property (fall_through_mode_q && !$past(we) && !$past(we, 2)
		&& !$past(master_reset_pulse_i) && !$past(master_reset_pulse_i, 2)
		|-> $stable(input_ready_flag_n_o)) else $error("Input ready moved off write edge");
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("Read answer late");
endmodule

bind pfl_flag_logic pfl_flag_sva i_pfl_flag_sva (.clk_i, .rst_i, .master_reset_pulse_i,
	.offset_load_select_i, .default_offset_select_0_i, .default_offset_select_1_i,
	.flag_timing_select_i, .fall_through_mode_i, .narrow_mode_i, .write_clock_i, .read_clock_i,
	.offset_readback_i, .almost_full_flag_n_o, .almost_empty_flag_n_o, .input_ready_flag_n_o,
	.output_ready_flag_n_o, .parallel_output_bus_o, .s_axi_arvalid_i, .s_axi_arready_o,
	.s_axi_rvalid_o);

// ==== verification/pfl_host_model.sv ====
/*
 Host side of the FIFO ports: write and read clocks with their requests.
 Assumes the system clock clk_i; one port clock period spans two clk cycles.
*/
`timescale 1ns/10ps
module pfl_host_model (
	input wire logic clk_i,
	output logic write_clock_o,
	output logic write_request_o,
	output logic read_clock_o,
	output logic read_request_o
);
	initial begin
		{write_clock_o, write_request_o, read_clock_o, read_request_o} = 4'h0;
	end
	// v = {write clock, write request, read clock, read request}
	task automatic port_cycle(input logic [3:0] v);
		@(posedge clk_i);
		{write_clock_o, write_request_o, read_clock_o, read_request_o} <= v;
		@(posedge clk_i);
		write_clock_o <= 1'b0;
		read_clock_o <= 1'b0;
		// Requests mean nothing between port edges, so scramble them
		write_request_o <= ~v[2];
		read_request_o <= ~v[0];
	endtask
endmodule

// ==== verification/testbench.sv ====
/*
 Testbench for pfl_flag_logic: defaults, offset loading, flags, interrupt.
 Drives the register bus itself and the FIFO ports through pfl_host_model.
*/
`timescale 1ns/10ps
module testbench
	import pfl_pkg::*;
;
	localparam logic [11:0] DEF [0:15] = '{12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h01f,
		12'h007, 12'h00f, 12'h003, 12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h3ff, 12'h00f,
		12'h01f, 12'h007};
	logic clk_i, rst_i, master_reset_pulse_i, offset_load_select_i, default_offset_select_0_i;
	logic default_offset_select_1_i, flag_timing_select_i, fall_through_mode_i, narrow_mode_i;
	logic write_clock_i, write_request_i, read_clock_i, read_request_i, serial_load_i;
	logic serial_data_i, offset_readback_i, almost_full_flag_n_o, almost_empty_flag_n_o;
	logic half_full_flag_n_o, input_ready_flag_n_o, output_ready_flag_n_o, irq_o;
	logic [PFL_Q_W-1:0] parallel_output_bus_o;
	logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
	logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
	logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	pfl_flag_logic i_pfl_flag_logic (.*);
	pfl_host_model i_host (.clk_i, .write_clock_o(write_clock_i),
		.write_request_o(write_request_i), .read_clock_o(read_clock_i),
		.read_request_o(read_request_i));
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			fails++;
		end
	endtask
	// Handshakes are sampled mid-cycle, where they stand for the coming edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_tk, w_tk, b_seen;
		logic [1:0] br;
		@(posedge clk_i);
		{s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		do begin
			@(negedge clk_i);
			aw_tk = s_axi_awvalid_i & s_axi_awready_o;
			w_tk = s_axi_wvalid_i & s_axi_wready_o;
			b_seen = s_axi_bvalid_o;
			br = s_axi_bresp_o;
			@(posedge clk_i);
			if (aw_tk) s_axi_awvalid_i <= 1'b0;
			if (w_tk) s_axi_wvalid_i <= 1'b0;
		end while (!b_seen);
		chk("bresp", er, br);
		s_axi_bready_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
		logic ar_tk, r_seen;
		logic [1:0] rr;
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		{s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
		do begin
			@(negedge clk_i);
			ar_tk = s_axi_arvalid_i & s_axi_arready_o;
			r_seen = s_axi_rvalid_o;
			d = s_axi_rdata_o;
			rr = s_axi_rresp_o;
			@(posedge clk_i);
			if (ar_tk) s_axi_arvalid_i <= 1'b0;
		end while (!r_seen);
		chk("rresp", er, rr);
		s_axi_rready_i <= 1'b0;
	endtask
	task automatic mres(input logic [5:0] s);
		@(posedge clk_i);
		{offset_load_select_i, default_offset_select_1_i, default_offset_select_0_i} <= s[5:3];
		{flag_timing_select_i, fall_through_mode_i, narrow_mode_i} <= s[2:0];
		master_reset_pulse_i <= 1'b1;
		@(posedge clk_i);
		master_reset_pulse_i <= 1'b0;
	endtask
	task automatic rback(output logic [31:0] e, output logic [31:0] f);
		offset_readback_i <= 1'b1;
		@(posedge clk_i);
		offset_readback_i <= 1'b0;
		@(posedge clk_i);
		e = parallel_output_bus_o;
		offset_readback_i <= 1'b1;
		@(posedge clk_i);
		offset_readback_i <= 1'b0;
		@(posedge clk_i);
		f = parallel_output_bus_o;
	endtask
	task automatic pc(input logic [3:0] v, input int n);
		repeat (n) i_host.port_cycle(v);
		@(posedge clk_i);
	endtask
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		logic [31:0] d, f;
		{rst_i, master_reset_pulse_i, offset_load_select_i, default_offset_select_0_i} = 4'h8;
		{default_offset_select_1_i, flag_timing_select_i, fall_through_mode_i} = 3'h0;
		{narrow_mode_i, serial_load_i, serial_data_i, offset_readback_i} = 4'h0;
		{s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
		s_axi_wstrb_i = 4'hf;
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = 4'h0;
		s_axi_rready_i = 1'b0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			mres({i[2:0], i[0], 1'b0, i[3]});
			rback(d, f);
			chk("empty default", DEF[i], d);
			chk("full default", DEF[i], f);
			rd(PFL_REG_CONFIG, PFL_RESP_OKAY, d);
			chk("config", {i[3], i[0], 1'b0, i[2]}, d);
		end
		rd(8'h20, PFL_RESP_SLVERR, d);
		wr(8'h24, 32'h0000_0001, PFL_RESP_SLVERR);
		mres(6'h20);
		wr(PFL_REG_EMPTY_OFF, 32'h0000_0005, PFL_RESP_OKAY);
		rd(PFL_REG_EMPTY_OFF, PFL_RESP_OKAY, d);
		chk("serial ignores bus", 32'h0000_001f, d);
		for (int i = 0; i < 24; i++) begin
			@(posedge clk_i);
			serial_data_i <= 1'(24'h00_9005 >> i);
			serial_load_i <= 1'b1;
		end
		@(posedge clk_i);
		serial_load_i <= 1'b0;
		rback(d, f);
		chk("serial empty", 32'h0000_0005, d);
		chk("serial full", 32'h0000_0009, f);
		mres(6'h06);
		@(posedge clk_i);
		chk("or empty", 1'b1, output_ready_flag_n_o);
		wr(PFL_REG_EMPTY_OFF, 32'h0000_0002, PFL_RESP_OKAY);
		wr(PFL_REG_FULL_OFF, 32'h0000_0003, PFL_RESP_OKAY);
		rd(PFL_REG_FULL_OFF, PFL_RESP_OKAY, d);
		chk("full offset", 32'h0000_0003, d);
		pc(4'hc, 1);
		pc(4'h2, 2);
		chk("or two stages", 1'b1, output_ready_flag_n_o);
		pc(4'h2, 1);
		chk("or first word", 1'b0, output_ready_flag_n_o);
		pc(4'hc, 3);
		chk("pae sync hold", 1'b0, almost_empty_flag_n_o);
		pc(4'h2, 1);
		chk("pae n plus 2", 1'b1, almost_empty_flag_n_o);
		pc(4'hc, 2046);
		pc(4'h8, 1);
		chk("ir full", 1'b1, input_ready_flag_n_o);
		chk("paf full", 1'b0, almost_full_flag_n_o);
		rd(PFL_REG_FLAGS, PFL_RESP_OKAY, d);
		chk("capacity", 13'h0801, d[12:0]);
		pc(4'h3, 1);
		pc(4'h8, 2);
		chk("ir first read", 1'b0, input_ready_flag_n_o);
		pc(4'h3, 3);
		chk("paf sync hold", 1'b0, almost_full_flag_n_o);
		pc(4'h8, 1);
		chk("paf release", 1'b1, almost_full_flag_n_o);
		pc(4'h3, 1019);
		chk("hf 1026", 1'b0, half_full_flag_n_o);
		pc(4'h3, 1);
		chk("hf 1025", 1'b1, half_full_flag_n_o);
		pc(4'h3, 1021);
		pc(4'h2, 1);
		chk("pae n plus 2 left", 1'b1, almost_empty_flag_n_o);
		pc(4'h3, 1);
		pc(4'h2, 1);
		chk("pae n plus 1 left", 1'b0, almost_empty_flag_n_o);
		pc(4'h3, 3);
		pc(4'h2, 3);
		chk("or last read", 1'b1, output_ready_flag_n_o);
		pc(4'h3, 1);
		rd(PFL_REG_FLAGS, PFL_RESP_OKAY, d);
		chk("empty read ignored", 13'h0000, d[12:0]);
		rd(PFL_REG_IRQ_STAT, PFL_RESP_OKAY, d);
		chk("refused events", 2'h3, d[3:2]);
		chk("irq masked", 1'b0, irq_o);
		wr(PFL_REG_IRQ_MASK, 32'h0000_0008, PFL_RESP_OKAY);
		chk("irq raised", 1'b1, irq_o);
		wr(PFL_REG_IRQ_STAT, 32'h0000_0008, PFL_RESP_OKAY);
		chk("irq cleared", 1'b0, irq_o);
		rd(PFL_REG_IRQ_STAT, PFL_RESP_OKAY, d);
		chk("w1c", 2'h1, d[3:2]);
		mres(6'h00);
		wr(PFL_REG_EMPTY_OFF, 32'h0000_0001, PFL_RESP_OKAY);
		wr(PFL_REG_FULL_OFF, 32'h0000_07ff, PFL_RESP_OKAY);
		pc(4'hc, 1);
		chk("paf async low", 1'b0, almost_full_flag_n_o);
		pc(4'hc, 1);
		chk("pae async high", 1'b1, almost_empty_flag_n_o);
		pc(4'h3, 1);
		chk("pae async low", 1'b0, almost_empty_flag_n_o);
		pc(4'h3, 1);
		chk("paf async high", 1'b1, almost_full_flag_n_o);
		stop_test();
	end
endmodule

// ==== verilog/pfl_flag_logic.sv ====
/*
 Programmable almost-empty/almost-full and ready flag logic of a FIFO, with
 default offsets, serial or parallel offset loading, offset readback and an
 AXI4-Lite register slave with a masked interrupt.
 Assumes write and read clocks are slower than clk_i and synchronous to it;
 only the word count is kept here, the data memory lives elsewhere.
*/
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
module pfl_flag_logic
	import pfl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic master_reset_pulse_i,
	input wire logic offset_load_select_i,
	input wire logic default_offset_select_0_i,
	input wire logic default_offset_select_1_i,
	input wire logic flag_timing_select_i,
	input wire logic fall_through_mode_i,
	input wire logic narrow_mode_i,
	input wire logic write_clock_i,
	input wire logic write_request_i,
	input wire logic read_clock_i,
	input wire logic read_request_i,
	input wire logic serial_load_i,
	input wire logic serial_data_i,
	input wire logic offset_readback_i,
	output logic almost_full_flag_n_o,
	output logic almost_empty_flag_n_o,
	output logic half_full_flag_n_o,
	output logic input_ready_flag_n_o,
	output logic output_ready_flag_n_o,
	output logic [PFL_Q_W-1:0] parallel_output_bus_o,
	output logic irq_o,
	input wire logic [PFL_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [PFL_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);
	pfl_state_t s;
	pfl_state_t next_s;

	logic wr_edge;
	logic rd_edge;
	logic do_wr;
	logic do_rd;
	logic [PFL_CNT_W-1:0] depth;
	logic [PFL_CNT_W-1:0] cap;
	logic [PFL_CNT_W:0] nc;
	logic [PFL_CNT_W:0] pae_thr;
	logic [PFL_CNT_W:0] hf_thr;
	logic paf_hit;
	logic pae_hit;
	logic empty_now;
	logic full_now;
	logic [PFL_OR_STAGES-1:0] or_stages;
	logic [PFL_IR_STAGES-1:0] ir_stages;
	logic ir_pin;
	logic or_pin;
	logic [31:0] wr_val;
	logic [PFL_IRQ_W-1:0] irq_clr;
	logic [PFL_IRQ_W-1:0] irq_ev;
	logic [31:0] empty_m;
	logic [31:0] full_m;
	logic [31:0] mask_m;

	function automatic logic pfl_mapped(input logic [PFL_ADDR_W-1:0] a);
		return (a == PFL_REG_CONFIG) || (a == PFL_REG_EMPTY_OFF) ||
			(a == PFL_REG_FULL_OFF) || (a == PFL_REG_FLAGS) ||
			(a == PFL_REG_IRQ_STAT) || (a == PFL_REG_IRQ_MASK);
	endfunction

	function automatic logic [31:0] pfl_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [PFL_OFF_W-1:0] pfl_default(input logic [2:0] sel,
		input logic narrow);
		return narrow ? PFL_DEF_NARROW[sel] : PFL_DEF_WIDE[sel];
	endfunction

	// Ready flags are the raw empty/full conditions delayed on their own port clocks
	pfl_flag_pipe #(
		.STAGES(PFL_OR_STAGES),
		.RESET_VAL(1'b1)
	) u_or_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(master_reset_pulse_i),
		.shift_i(rd_edge),
		.d_i(empty_now),
		.stages_o(or_stages)
	);

	pfl_flag_pipe #(
		.STAGES(PFL_IR_STAGES),
		.RESET_VAL(1'b0)
	) u_ir_pipe (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(master_reset_pulse_i),
		.shift_i(wr_edge),
		.d_i(full_now),
		.stages_o(ir_stages)
	);

	// Fall-through: ready flags are active low; standard mode shows active-low full/empty
	assign or_pin = s.cfg_fall_through_mode ? or_stages[PFL_OR_STAGES-1] :
		~or_stages[PFL_STD_STAGES-1];
	assign ir_pin = s.cfg_fall_through_mode ? ir_stages[PFL_IR_STAGES-1] :
		~ir_stages[PFL_STD_STAGES-1];

	always_comb begin
		next_s = s;
		irq_clr = '0;
		irq_ev = '0;
		wr_val = pfl_merge(32'h0000_0000, s.w_data, s.w_strb);
		empty_m = pfl_merge({20'h0_0000, s.empty_off}, s.w_data, s.w_strb);
		full_m = pfl_merge({20'h0_0000, s.full_off}, s.w_data, s.w_strb);
		mask_m = pfl_merge({28'h000_0000, s.irq_mask}, s.w_data, s.w_strb);

		wr_edge = write_clock_i & ~s.wclk_q;
		rd_edge = read_clock_i & ~s.rclk_q;
		next_s.wclk_q = write_clock_i;
		next_s.rclk_q = read_clock_i;

		depth = s.cfg_narrow ? PFL_DEPTH_NARROW : PFL_DEPTH_WIDE;
		// Output register adds one word of capacity in fall-through mode
		cap = s.cfg_fall_through_mode ? depth + 13'h0001 : depth;
		do_wr = wr_edge & write_request_i & (s.count != cap);
		do_rd = rd_edge & read_request_i & (s.count != 13'h0000);
		nc = {1'b0, s.count} + {13'h0000, do_wr} - {13'h0000, do_rd};
		next_s.count = nc[PFL_CNT_W-1:0];
		empty_now = (nc == 14'h0000);
		full_now = (nc == {1'b0, cap});

		pae_thr = {2'h0, s.empty_off} + (s.cfg_fall_through_mode ? 14'h0001 : 14'h0000);
		hf_thr = {2'h0, depth[PFL_CNT_W-1:1]} + (s.cfg_fall_through_mode ? 14'h0002 : 14'h0001);
		// Below threshold at offset+1 words, above from offset+2 in fall-through
		pae_hit = (nc <= pae_thr);
		// Compare as count + m >= capacity so a large offset cannot underflow
		paf_hit = ((nc + {2'h0, s.full_off}) >= {1'b0, cap});

		if (s.cfg_sync) begin
			if (wr_edge) begin
				next_s.paf_n = ~paf_hit;
			end
			if (rd_edge) begin
				next_s.pae_n = ~pae_hit;
			end
		end else begin
			if (wr_edge && paf_hit) begin
				next_s.paf_n = 1'b0;
			end
			if (rd_edge && !paf_hit) begin
				next_s.paf_n = 1'b1;
			end
			if (rd_edge && pae_hit) begin
				next_s.pae_n = 1'b0;
			end
			if (wr_edge && !pae_hit) begin
				next_s.pae_n = 1'b1;
			end
		end
		next_s.hf_n = ~(nc >= hf_thr);

		irq_ev[PFL_IRQ_PAF] = s.paf_n & ~next_s.paf_n;
		irq_ev[PFL_IRQ_PAE] = s.pae_n & ~next_s.pae_n;
		irq_ev[PFL_IRQ_WR_REFUSED] = wr_edge & write_request_i & (s.count == cap);
		irq_ev[PFL_IRQ_RD_REFUSED] = rd_edge & read_request_i & (s.count == 13'h0000);

		// Serial loading shifts empty offset first, LSB first, then full offset
		if (s.cfg_serial && serial_load_i) begin
			{next_s.full_off, next_s.empty_off} = {serial_data_i,
				s.full_off, s.empty_off[PFL_OFF_W-1:1]};
		end

		// Readback pulses present one offset each in turn: the empty offset first, then the full offset
		if (offset_readback_i) begin
			next_s.q_bus = {6'h00, s.rb_sel ? s.full_off : s.empty_off};
			next_s.rb_sel = ~s.rb_sel;
		end

		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_s.aw_hold = 1'b1;
			next_s.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_s.w_hold = 1'b1;
			next_s.w_data = s_axi_wdata_i;
			next_s.w_strb = s_axi_wstrb_i;
		end
		if (s.aw_hold && s.w_hold) begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = pfl_mapped(s.aw_addr) ? PFL_RESP_OKAY : PFL_RESP_SLVERR;
			unique case (s.aw_addr)
				PFL_REG_EMPTY_OFF: begin
					// Parallel loading is the software path; ignored in serial mode
					if (!s.cfg_serial) begin
						next_s.empty_off = empty_m[PFL_OFF_W-1:0];
					end
				end
				PFL_REG_FULL_OFF: begin
					if (!s.cfg_serial) begin
						next_s.full_off = full_m[PFL_OFF_W-1:0];
					end
				end
				PFL_REG_IRQ_STAT: begin
					irq_clr = wr_val[PFL_IRQ_W-1:0];
				end
				PFL_REG_IRQ_MASK: begin
					next_s.irq_mask = mask_m[PFL_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (s.bvalid && s_axi_bready_i) begin
			next_s.bvalid = 1'b0;
		end

		if (s_axi_arvalid_i && s_axi_arready_o) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = pfl_mapped(s_axi_araddr_i) ? PFL_RESP_OKAY : PFL_RESP_SLVERR;
			next_s.rdata = 32'h0000_0000;
			unique case (s_axi_araddr_i)
				PFL_REG_CONFIG: begin
					next_s.rdata[PFL_CFG_SERIAL] = s.cfg_serial;
					next_s.rdata[PFL_CFG_FALL_THROUGH_MODE] = s.cfg_fall_through_mode;
					next_s.rdata[PFL_CFG_SYNC] = s.cfg_sync;
					next_s.rdata[PFL_CFG_NARROW] = s.cfg_narrow;
				end
				PFL_REG_EMPTY_OFF: next_s.rdata[PFL_OFF_W-1:0] = s.empty_off;
				PFL_REG_FULL_OFF: next_s.rdata[PFL_OFF_W-1:0] = s.full_off;
				PFL_REG_FLAGS: begin
					next_s.rdata[PFL_FLG_COUNT +: PFL_CNT_W] = s.count;
					next_s.rdata[PFL_FLG_PAF_N] = s.paf_n;
					next_s.rdata[PFL_FLG_PAE_N] = s.pae_n;
					next_s.rdata[PFL_FLG_HF_N] = s.hf_n;
					next_s.rdata[PFL_FLG_IR] = ir_pin;
					next_s.rdata[PFL_FLG_OR] = or_pin;
				end
				PFL_REG_IRQ_STAT: next_s.rdata[PFL_IRQ_W-1:0] = s.irq_stat;
				PFL_REG_IRQ_MASK: next_s.rdata[PFL_IRQ_W-1:0] = s.irq_mask;
				default: begin
				end
			endcase
		end else if (s.rvalid && s_axi_rready_i) begin
			next_s.rvalid = 1'b0;
		end

		// A new event wins over a clear in the same cycle
		next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_ev;

		// Master reset empties the FIFO and captures the configuration straps
		if (master_reset_pulse_i) begin
			next_s.cfg_serial = offset_load_select_i;
			next_s.cfg_sync = flag_timing_select_i;
			next_s.cfg_fall_through_mode = fall_through_mode_i;
			next_s.cfg_narrow = narrow_mode_i;
			next_s.empty_off = pfl_default({offset_load_select_i, default_offset_select_1_i,
				default_offset_select_0_i}, narrow_mode_i);
			next_s.full_off = next_s.empty_off;
			next_s.count = 13'h0000;
			next_s.paf_n = 1'b1;
			next_s.pae_n = 1'b0;
			next_s.hf_n = 1'b1;
			next_s.rb_sel = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
			s.empty_off <= PFL_OFF_RESET;
			s.full_off <= PFL_OFF_RESET;
			s.paf_n <= 1'b1;
			s.hf_n <= 1'b1;
			s.irq_stat <= PFL_IRQ_RESET;
			s.irq_mask <= PFL_IRQ_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign almost_full_flag_n_o = s.paf_n;
	assign almost_empty_flag_n_o = s.pae_n;
	assign half_full_flag_n_o = s.hf_n;
	assign input_ready_flag_n_o = ir_pin;
	assign output_ready_flag_n_o = or_pin;
	assign parallel_output_bus_o = s.q_bus;
	assign irq_o = |(s.irq_stat & s.irq_mask);

	assign s_axi_awready_o = ~s.aw_hold & ~s.bvalid;
	assign s_axi_wready_o = ~s.w_hold & ~s.bvalid;
	assign s_axi_bvalid_o = s.bvalid;
	assign s_axi_bresp_o = s.bresp;
	assign s_axi_arready_o = ~s.rvalid;
	assign s_axi_rvalid_o = s.rvalid;
	assign s_axi_rdata_o = s.rdata;
	assign s_axi_rresp_o = s.rresp;
endmodule

// ==== verilog/pfl_flag_pipe.sv ====
/*
 Register stage chain for a status flag; shifts only on the enable,
 which marks a rising edge of the FIFO port clock that owns the flag.
 Assumes enable and clear are synchronous to clk_i.
*/
`timescale 1ns/10ps
module pfl_flag_pipe #(
	parameter int STAGES = 2,
	parameter logic RESET_VAL = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic shift_i,
	input wire logic d_i,
	output logic [STAGES-1:0] stages_o
);
	logic [STAGES-1:0] stages;
	logic [STAGES-1:0] next_stages;
	logic [STAGES-1:0] chain_in;

	assign chain_in[0] = d_i;
	genvar gi;
	generate
		for (gi = 1; gi < STAGES; gi++) begin : g_chain
			assign chain_in[gi] = stages[gi-1];
		end
	endgenerate

	always_comb begin
		next_stages = stages;
		if (clear_i) begin
			next_stages = {STAGES{RESET_VAL}};
		end else if (shift_i) begin
			next_stages = chain_in;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stages <= {STAGES{RESET_VAL}};
		end else begin
			stages <= next_stages;
		end
	end

	assign stages_o = stages;
endmodule

// ==== verilog/pfl_pkg.sv ====
/*
 Package for the programmable flag logic of a dual-clock FIFO: register map,
 field positions, reset values, depths and default offset tables.
 Assumes a single system clock; the FIFO's write and read clocks arrive as
 plain inputs sampled on that clock.
*/
// Overview of operation
// - Master reset loads one of eight default empty/full offset pairs from select pins.
// - Default offsets 1023 down to 3; smallest depth 511 to 3, x9 1023 to 7.
// - Fall-through mode capacity is depth plus one word for the output register.
// - Full in fall-through: first read lowers input ready; later reads raise almost/half-full.
// - Fall-through, reads only: almost-empty goes low at empty offset plus one words.
// - Fall-through: last word read raises output ready; reads while empty are ignored.
// - Output ready passes three read-clock stages, input ready two write-clock stages.
// - Load select held during master reset picks serial (high) or parallel (low) loading.
// - Offsets can be read back on the parallel output bus; no serial readback.
// - Offsets may be reprogrammed any time after master reset; values 0 to depth-1.
// - Flag timing select latched at master reset: high synchronous, low asynchronous.
// - Synchronous mode: almost-full changes on write clock, almost-empty on read clock only.
// - Asynchronous mode: almost-full falls on write clock, rises on read clock.
// - Asynchronous mode: almost-empty falls on read clock edge.
// - Fall-through: first write lowers output ready; almost-empty rises at offset plus two.
package pfl_pkg;
	localparam int PFL_OFF_W = 12;
	localparam int PFL_CNT_W = 13;
	localparam int PFL_Q_W = 18;
	localparam int PFL_ADDR_W = 8;
	localparam int PFL_IRQ_W = 4;

	localparam logic [PFL_CNT_W-1:0] PFL_DEPTH_WIDE = 13'h0800;
	localparam logic [PFL_CNT_W-1:0] PFL_DEPTH_NARROW = 13'h1000;

	localparam int PFL_IR_STAGES = 2;
	localparam int PFL_OR_STAGES = 3;
	localparam int PFL_STD_STAGES = 2;

	// Indexed by {load select, select 1, select 0}
	localparam logic [PFL_OFF_W-1:0] PFL_DEF_WIDE [0:7] = '{
		12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h01f, 12'h007, 12'h00f, 12'h003};
	localparam logic [PFL_OFF_W-1:0] PFL_DEF_NARROW [0:7] = '{
		12'h07f, 12'h0ff, 12'h1ff, 12'h03f, 12'h3ff, 12'h00f, 12'h01f, 12'h007};

	localparam logic [PFL_ADDR_W-1:0] PFL_REG_CONFIG = 8'h00;
	localparam logic [PFL_ADDR_W-1:0] PFL_REG_EMPTY_OFF = 8'h04;
	localparam logic [PFL_ADDR_W-1:0] PFL_REG_FULL_OFF = 8'h08;
	localparam logic [PFL_ADDR_W-1:0] PFL_REG_FLAGS = 8'h0c;
	localparam logic [PFL_ADDR_W-1:0] PFL_REG_IRQ_STAT = 8'h10;
	localparam logic [PFL_ADDR_W-1:0] PFL_REG_IRQ_MASK = 8'h14;

	localparam int PFL_CFG_SERIAL = 0;
	localparam int PFL_CFG_FALL_THROUGH_MODE = 1;
	localparam int PFL_CFG_SYNC = 2;
	localparam int PFL_CFG_NARROW = 3;

	localparam int PFL_FLG_COUNT = 0;
	localparam int PFL_FLG_PAF_N = 16;
	localparam int PFL_FLG_PAE_N = 17;
	localparam int PFL_FLG_HF_N = 18;
	localparam int PFL_FLG_IR = 19;
	localparam int PFL_FLG_OR = 20;

	localparam int PFL_IRQ_PAF = 0;
	localparam int PFL_IRQ_PAE = 1;
	localparam int PFL_IRQ_WR_REFUSED = 2;
	localparam int PFL_IRQ_RD_REFUSED = 3;

	localparam logic [1:0] PFL_RESP_OKAY = 2'h0;
	localparam logic [1:0] PFL_RESP_SLVERR = 2'h2;
	localparam logic [PFL_OFF_W-1:0] PFL_OFF_RESET = 12'h07f;
	localparam logic [PFL_IRQ_W-1:0] PFL_IRQ_RESET = 4'h0;

	typedef struct packed {
		logic wclk_q;
		logic rclk_q;
		logic cfg_serial;
		logic cfg_fall_through_mode;
		logic cfg_sync;
		logic cfg_narrow;
		logic [PFL_OFF_W-1:0] empty_off;
		logic [PFL_OFF_W-1:0] full_off;
		logic [PFL_CNT_W-1:0] count;
		logic paf_n;
		logic pae_n;
		logic hf_n;
		logic rb_sel;
		logic [PFL_Q_W-1:0] q_bus;
		logic [PFL_IRQ_W-1:0] irq_stat;
		logic [PFL_IRQ_W-1:0] irq_mask;
		logic aw_hold;
		logic [PFL_ADDR_W-1:0] aw_addr;
		logic w_hold;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pfl_state_t;
endpackage
